// ---- rtl/holdover_pkg.sv ----
package holdover_pkg;
  localparam logic [9:0] ADDR_STATUS_SEL = 10'h017;
  localparam logic [9:0] ADDR_LOCK_CFG   = 10'h018;
  localparam logic [9:0] ADDR_LOCK_PIN   = 10'h01a;
  localparam logic [9:0] ADDR_MON_SEL    = 10'h01b;
  localparam logic [9:0] ADDR_REF_CFG    = 10'h01c;
  localparam logic [9:0] ADDR_HOLD_CFG   = 10'h01d;
  localparam logic [9:0] ADDR_READBACK   = 10'h01f;

  localparam int HOLD_EN_A_BIT  = 0;
  localparam int HOLD_EXT_BIT   = 1;
  localparam int HOLD_EN_B_BIT  = 2;
  localparam int CMP_EN_BIT     = 3;
  localparam int LOCK_CNT_LSB   = 5;
  localparam int LOCK_WIN_BIT   = 4;
  localparam int LOCK_DIS_BIT   = 3;
  localparam int STATUS_SEL_LSB = 2;
  localparam int REF_SEL_BIT    = 6;
  localparam int RB_LOCK_BIT    = 0;
  localparam int RB_HOLD_BIT    = 4;
  localparam int RB_CMP_BIT     = 5;
  localparam int RB_ARMED_BIT   = 7;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam logic [5:0] LOCK_PIN_CURRENT_SRC = 6'h04;

  localparam logic [5:0] MON_LOCK_HIGH = 6'h01;
  localparam logic [5:0] MON_CMP_HIGH  = 6'h02;
  localparam logic [5:0] MON_CMP_LOW   = 6'h03;
  localparam logic [5:0] MON_HOLD      = 6'h04;

  localparam logic [7:0] LOCK_COUNT_0 = 8'h05;
  localparam logic [7:0] LOCK_COUNT_1 = 8'h10;
  localparam logic [7:0] LOCK_COUNT_2 = 8'h40;
  localparam logic [7:0] LOCK_COUNT_3 = 8'hff;

  localparam logic [7:0] LOCK_THR_HIGH   = 8'h28;
  localparam logic [7:0] UNLOCK_THR_HIGH = 8'h3c;
  localparam logic [7:0] LOCK_THR_LOW    = 8'h0c;
  localparam logic [7:0] UNLOCK_THR_LOW  = 8'h12;

  typedef enum logic [2:0] {
    ST_ARMED = 3'b001,
    ST_HOLD  = 3'b010,
    ST_REARM = 3'b100
  } hold_state_e;
endpackage

// ---- rtl/lock_detect.sv ----
`timescale 1ns/100ps
module lock_detect #(
  parameter int DIFF_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              phase_cycle_i,
  input  wire logic [DIFF_W-1:0] phase_diff_i,
  input  wire logic              window_low_i,
  input  wire logic [1:0]        count_code_i,
  input  wire logic              disable_i,
  output logic                   lock_o
);
  if (DIFF_W < 8) begin : g_bad_width
    $error("DIFF_W must be at least 8");
  end

  logic [7:0]        run;
  logic [7:0]        need;
  logic [DIFF_W-1:0] lock_thr;
  logic [DIFF_W-1:0] unlock_thr;

  always_comb begin
    case (count_code_i)
      2'b00:   need = holdover_pkg::LOCK_COUNT_0;
      2'b01:   need = holdover_pkg::LOCK_COUNT_1;
      2'b10:   need = holdover_pkg::LOCK_COUNT_2;
      default: need = holdover_pkg::LOCK_COUNT_3;
    endcase
  end

  // Window bit clear means the wide, high-range thresholds
  assign lock_thr   = window_low_i ? DIFF_W'(holdover_pkg::LOCK_THR_LOW)
                                   : DIFF_W'(holdover_pkg::LOCK_THR_HIGH);
  assign unlock_thr = window_low_i ? DIFF_W'(holdover_pkg::UNLOCK_THR_LOW)
                                   : DIFF_W'(holdover_pkg::UNLOCK_THR_HIGH);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run <= 8'h00;
    end else if (disable_i) begin
      run <= 8'h00;
    end else if (phase_cycle_i) begin
      if (phase_diff_i < lock_thr) begin
        run <= (run == 8'hff) ? run : run + 8'h01;
      end else begin
        run <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_o <= 1'b0;
    end else if (disable_i) begin
      lock_o <= 1'b0;
    end else if (phase_cycle_i) begin
      if (lock_o && phase_diff_i > unlock_thr) begin
        lock_o <= 1'b0;
      end else if (!lock_o && phase_diff_i < lock_thr && run + 8'h01 >= need) begin
        lock_o <= 1'b1;
      end
    end
  end
endmodule

// ---- rtl/holdover_ctrl.sv ----
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module holdover_ctrl #(
  parameter int DIFF_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [9:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              sync_n_i,
  input  wire logic              ref1_edge_i,
  input  wire logic              ref2_edge_i,
  input  wire logic              fb_edge_i,
  input  wire logic [DIFF_W-1:0] phase_diff_i,
  input  wire logic              lock_cmp_i,
  output logic                   charge_pump_hiz_o,
  output logic                   b_counter_reset_o,
  output logic                   lock_pin_isrc_o,
  output logic                   lock_pin_gnd_o,
  output logic                   reference_monitor_pin_o,
  output logic                   status_pin_o
);
  if (DIFF_W < 8) begin : g_bad_width
    $error("DIFF_W must be at least 8");
  end

  // Register storage
  logic [7:0] status_sel_reg;
  logic [7:0] lock_cfg_reg;
  logic [7:0] lock_pin_reg;
  logic [7:0] mon_sel_reg;
  logic [7:0] ref_cfg_reg;
  logic [7:0] hold_cfg_reg;

  // Input synchronisers: bit 0 sync pin, bit 1 comparator
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic       sync_pin_prev;

  logic                      digital_lock_flag;
  logic                      phase_cycle;
  logic                      ref_edge;
  logic                      hold_enabled;
  logic                      manual_mode;
  logic                      lock_sensed;
  logic                      sync_fall;
  logic                      enter_manual;
  logic                      enter_auto;
  logic                      entry;
  logic                      release_now;
  logic                      current_src_mode;
  holdover_pkg::hold_state_e state;
  holdover_pkg::hold_state_e next_state;
  logic [7:0]                readback;
  logic [7:0]                next_rdata;

  // Pin mux decode shared by the monitor pin and the status pin
  function automatic logic pin_select(input logic [5:0] code,
                                      input logic       cmp,
                                      input logic       locked,
                                      input logic       hold);
    logic val;
    val = 1'b0;
    case (code)
      holdover_pkg::MON_LOCK_HIGH: val = locked;
      holdover_pkg::MON_CMP_HIGH:  val = cmp;
      holdover_pkg::MON_CMP_LOW:   val = ~cmp;
      holdover_pkg::MON_HOLD:      val = hold;
      default:                     val = 1'b0;
    endcase
    return val;
  endfunction

  // Register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_sel_reg <= holdover_pkg::RESET_BYTE;
      lock_cfg_reg   <= holdover_pkg::RESET_BYTE;
      lock_pin_reg   <= holdover_pkg::RESET_BYTE;
      mon_sel_reg    <= holdover_pkg::RESET_BYTE;
      ref_cfg_reg    <= holdover_pkg::RESET_BYTE;
      hold_cfg_reg   <= holdover_pkg::RESET_BYTE;
    end else if (wr_i) begin
      case (addr_i)
        holdover_pkg::ADDR_STATUS_SEL: status_sel_reg <= wdata_i;
        holdover_pkg::ADDR_LOCK_CFG:   lock_cfg_reg   <= wdata_i;
        holdover_pkg::ADDR_LOCK_PIN:   lock_pin_reg   <= {2'b00, wdata_i[5:0]};
        holdover_pkg::ADDR_MON_SEL:    mon_sel_reg    <= wdata_i;
        holdover_pkg::ADDR_REF_CFG:    ref_cfg_reg    <= wdata_i;
        holdover_pkg::ADDR_HOLD_CFG:   hold_cfg_reg   <= {4'h0, wdata_i[3:0]};
        default:                       ;
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_comb begin
    readback = 8'h00;
    readback[holdover_pkg::RB_LOCK_BIT]  = digital_lock_flag;
    readback[holdover_pkg::RB_HOLD_BIT]  = charge_pump_hiz_o;
    readback[holdover_pkg::RB_CMP_BIT]   = sync_b[1];
    readback[holdover_pkg::RB_ARMED_BIT] = (state == holdover_pkg::ST_ARMED);
  end

  always_comb begin
    case (addr_i)
      holdover_pkg::ADDR_STATUS_SEL: next_rdata = status_sel_reg;
      holdover_pkg::ADDR_LOCK_CFG:   next_rdata = lock_cfg_reg;
      holdover_pkg::ADDR_LOCK_PIN:   next_rdata = lock_pin_reg;
      holdover_pkg::ADDR_MON_SEL:    next_rdata = mon_sel_reg;
      holdover_pkg::ADDR_REF_CFG:    next_rdata = ref_cfg_reg;
      holdover_pkg::ADDR_HOLD_CFG:   next_rdata = hold_cfg_reg;
      holdover_pkg::ADDR_READBACK:   next_rdata = readback;
      default:                       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Two-flop synchronisers; only the second stage feeds any logic
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync_a[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        sync_b[gi] <= (gi == 0) ? 1'b1 : 1'b0;
      end else begin
        sync_a[gi] <= (gi == 0) ? sync_n_i : lock_cmp_i;
        sync_b[gi] <= sync_a[gi];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_pin_prev <= 1'b1;
    end else begin
      sync_pin_prev <= sync_b[0];
    end
  end

  // Only the selected reference path can end holdover
  assign ref_edge  = ref_cfg_reg[holdover_pkg::REF_SEL_BIT] ? ref2_edge_i
                                                           : ref1_edge_i;
  assign phase_cycle = ref_edge;

  lock_detect #(
    .DIFF_W (DIFF_W)
  ) u_lock_detect (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .phase_cycle_i (phase_cycle),
    .phase_diff_i  (phase_diff_i),
    .window_low_i  (lock_cfg_reg[holdover_pkg::LOCK_WIN_BIT]),
    .count_code_i  (lock_cfg_reg[holdover_pkg::LOCK_CNT_LSB +: 2]),
    .disable_i     (lock_cfg_reg[holdover_pkg::LOCK_DIS_BIT]),
    .lock_o        (digital_lock_flag)
  );

  // Holdover qualification
  assign hold_enabled = hold_cfg_reg[holdover_pkg::HOLD_EN_A_BIT] &
                        hold_cfg_reg[holdover_pkg::HOLD_EN_B_BIT];
  assign manual_mode  = hold_cfg_reg[holdover_pkg::HOLD_EXT_BIT];
  // A disabled comparator reads as locked, so automatic entry never fires
  assign lock_sensed  = hold_cfg_reg[holdover_pkg::CMP_EN_BIT] ? sync_b[1] : 1'b1;
  assign sync_fall    = sync_pin_prev & ~sync_b[0];

  assign enter_manual = hold_enabled & manual_mode & sync_fall &
                        (state != holdover_pkg::ST_HOLD);
  assign enter_auto   = hold_enabled & ~manual_mode & ~lock_sensed &
                        (state == holdover_pkg::ST_ARMED);
  assign entry        = enter_manual | enter_auto;

  // Release waits for the sync pin to be back high in manual mode
  assign release_now  = (state == holdover_pkg::ST_HOLD) & hold_enabled & ref_edge &
                        (~manual_mode | sync_b[0]);

  always_comb begin
    next_state = state;
    case (state)
      holdover_pkg::ST_ARMED: begin
        if (entry) begin
          next_state = holdover_pkg::ST_HOLD;
        end
      end
      holdover_pkg::ST_HOLD: begin
        if (!hold_enabled) begin
          next_state = holdover_pkg::ST_ARMED;
        end else if (release_now) begin
          next_state = manual_mode ? holdover_pkg::ST_ARMED
                                   : holdover_pkg::ST_REARM;
        end else begin
          next_state = holdover_pkg::ST_HOLD;
        end
      end
      holdover_pkg::ST_REARM: begin
        if (enter_manual) begin
          next_state = holdover_pkg::ST_HOLD;
        end else if (!hold_enabled || manual_mode) begin
          next_state = holdover_pkg::ST_ARMED;
        end else if (digital_lock_flag && lock_sensed) begin
          next_state = holdover_pkg::ST_ARMED;
        end
      end
      default: next_state = holdover_pkg::ST_ARMED;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= holdover_pkg::ST_ARMED;
    end else begin
      state <= next_state;
    end
  end

  // Entry is combinational so the pump stops in the cycle the cause is seen
  assign charge_pump_hiz_o = (state == holdover_pkg::ST_HOLD) | entry;
  // Only the B counter is reset; the prescaler keeps running
  assign b_counter_reset_o = release_now;

  // Current-source lock indicator on the lock pin
  assign current_src_mode = (lock_pin_reg[5:0] == holdover_pkg::LOCK_PIN_CURRENT_SRC);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_pin_isrc_o <= 1'b0;
      lock_pin_gnd_o  <= 1'b0;
    end else begin
      lock_pin_isrc_o <= current_src_mode & digital_lock_flag;
      lock_pin_gnd_o  <= current_src_mode & ~digital_lock_flag;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reference_monitor_pin_o <= 1'b0;
      status_pin_o            <= 1'b0;
    end else begin
      reference_monitor_pin_o <= pin_select({1'b0, mon_sel_reg[4:0]}, sync_b[1],
                                            digital_lock_flag, charge_pump_hiz_o);
      status_pin_o            <= pin_select(status_sel_reg[holdover_pkg::STATUS_SEL_LSB +: 6],
                                            sync_b[1], digital_lock_flag,
                                            charge_pump_hiz_o);
    end
  end
endmodule

// ---- verif/holdover_ctrl_asserts.sv ----
`timescale 1ns/100ps
module holdover_ctrl_checker #(
  parameter int DIFF_W = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [9:0]        addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  input wire logic              sync_n_i,
  input wire logic              ref1_edge_i,
  input wire logic              ref2_edge_i,
  input wire logic              fb_edge_i,
  input wire logic [DIFF_W-1:0] phase_diff_i,
  input wire logic              lock_cmp_i,
  input wire logic              charge_pump_hiz_o,
  input wire logic              b_counter_reset_o,
  input wire logic              lock_pin_isrc_o,
  input wire logic              lock_pin_gnd_o,
  input wire logic              reference_monitor_pin_o,
  input wire logic              status_pin_o
);
  logic [3:0] hold_cfg;
  logic [5:0] pin_sel;
  logic       ref_sel;
  logic       en;

  // Shadows follow the same write edge as the block, so no extra lag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cfg <= 4'h0;
      pin_sel  <= 6'h00;
      ref_sel  <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        10'h01d: hold_cfg <= wdata_i[3:0];
        10'h01a: pin_sel <= wdata_i[5:0];
        10'h01c: ref_sel <= wdata_i[6];
        default: ;
      endcase
    end
  end

  assign en = hold_cfg[0] && hold_cfg[2];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_in_hold: assert property (b_counter_reset_o |-> charge_pump_hiz_o)
    else $error("counter reset outside holdover");
  a_reset_on_ref: assert property (b_counter_reset_o |-> (ref_sel ? ref2_edge_i : ref1_edge_i))
    else $error("release without selected edge");
  a_release_drop: assert property (b_counter_reset_o |=> !charge_pump_hiz_o)
    else $error("pump stayed off after release");
  a_hold_off: assert property (!en && !$past(en) && !$past(en, 2) |-> !charge_pump_hiz_o)
    else $error("holdover while disabled");
  a_manual_entry: assert property (en && hold_cfg[1] && $fell(sync_n_i) |-> ##[1:4] charge_pump_hiz_o)
    else $error("no holdover after sync fall");
  a_hiz_hold: assert property (charge_pump_hiz_o && !b_counter_reset_o && en |=> charge_pump_hiz_o || !en)
    else $error("holdover left without edge");
  a_pin_drive: assert property (pin_sel == 6'h04 && $past(pin_sel) == 6'h04 |->
    lock_pin_isrc_o != lock_pin_gnd_o)
    else $error("lock pin drive wrong");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
endmodule

bind holdover_ctrl holdover_ctrl_checker #(.DIFF_W(DIFF_W)) i_holdover_ctrl_checker (
  .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sync_n_i, .ref1_edge_i, .ref2_edge_i,
  .fb_edge_i, .phase_diff_i, .lock_cmp_i, .charge_pump_hiz_o, .b_counter_reset_o, .lock_pin_isrc_o,
  .lock_pin_gnd_o, .reference_monitor_pin_o, .status_pin_o
);

// ---- verif/lock_cap_model.sv ----
`timescale 1ns/100ps
module lock_cap_model #(
  parameter int CHARGE = 6
) (
  input  wire logic clk_i,
  input  wire logic isrc_i,
  input  wire logic gnd_i,
  output logic      cmp_o
);
  int level = 0;

  // Grounding empties the capacitor at once; charging takes CHARGE cycles
  always @(posedge clk_i) begin
    if (gnd_i) begin
      level <= 0;
    end else if (isrc_i && level < CHARGE) begin
      level <= level + 1;
    end
  end

  assign cmp_o = (level >= CHARGE);
endmodule

// ---- verif/tb_holdover_ctrl.sv ----
`timescale 1ns/100ps
module tb_holdover_ctrl;
  typedef struct {logic [7:0] e; logic [7:0] m;} note_s;
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic [9:0]  addr_i       = 10'h000;
  logic [7:0]  wdata_i      = 8'h00;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic        sync_n_i     = 1'b1;
  logic        ref1_edge_i  = 1'b0;
  logic        ref2_edge_i  = 1'b0;
  logic        fb_edge_i    = 1'b0;
  logic [7:0]  phase_diff_i = 8'h00;
  logic        lock_cmp_i;
  logic [7:0]  rdata_o;
  logic [5:0]  pins;
  logic        rd_seen      = 1'b0;
  bit          pk           = 1'b0;
  logic [31:0] seed         = 32'h3ab3;
  logic [9:0]  regs[7]      = '{10'h017, 10'h018, 10'h01a, 10'h01b, 10'h01c, 10'h01d, 10'h3ff};
  logic [7:0]  half[2]      = '{8'h03, 8'h06};
  note_s       q[$];
  int          mismatches   = 0;
  int          tests_run    = 0;
  int          cycles       = 0;

  holdover_ctrl #(.DIFF_W(8)) i_holdover_ctrl (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sync_n_i, .ref1_edge_i, .ref2_edge_i,
    .fb_edge_i, .phase_diff_i, .lock_cmp_i, .charge_pump_hiz_o(pins[5]), .b_counter_reset_o(pins[4]),
    .lock_pin_isrc_o(pins[3]), .lock_pin_gnd_o(pins[2]), .reference_monitor_pin_o(pins[1]),
    .status_pin_o(pins[0])
  );
  lock_cap_model i_lock_cap_model (.clk_i, .isrc_i(pins[3]), .gnd_i(pins[2]), .cmp_o(lock_cmp_i));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) rd_seen <= rd_i;

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Read data is compared before pins so the queue order matches issue order
  always @(negedge clk_i) begin
    if (rd_seen) check(rdata_o);
    if (pk) begin
      check({2'b00, pins});
      pk = 1'b0;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] got);
    note_s n;
    n = q.pop_front();
    tests_run++;
    if ((got & n.m) !== n.e) begin
      mismatches++;
      $display("Error at %0t: saw %h wanted %h", $time, got & n.m, n.e);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back('{e, m});
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic peek(input logic [7:0] e, input logic [7:0] m);
    q.push_back('{e, m});
    pk = 1'b1;
    @(negedge clk_i);
  endtask

  task automatic pulse(input logic sel, input logic [7:0] d, input logic ck, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_i);
    ref1_edge_i  <= !sel;
    ref2_edge_i  <= sel;
    fb_edge_i    <= 1'b1;
    phase_diff_i <= d;
    if (ck) peek(e, m);
    @(posedge clk_i);
    ref1_edge_i <= 1'b0;
    ref2_edge_i <= 1'b0;
    fb_edge_i   <= 1'b0;
  endtask

  task automatic locks(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      pulse(1'b0, seed[7:0] % 8'd40, 1'b0, 8'h00, 8'h00);
    end
  endtask

  task automatic sync_to(input logic v, input int n);
    @(posedge clk_i);
    sync_n_i <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic mux(input logic l, input logic c);
    logic v;
    for (int k = 1; k < 4; k++) begin
      wr(10'h01b, 8'(k));
      wr(10'h017, 8'(k << 2));
      repeat (4) @(posedge clk_i);
      v = (k == 1) ? l : (k == 2) ? c : !c;
      peek({6'h00, v, v}, 8'h03);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(10'h01f, 8'hff);
    foreach (regs[i]) rd(regs[i], 8'h00, 8'hff);
    rd(10'h01f, 8'h80, 8'h91);
    $display("register defaults done");
    foreach (half[i]) begin
      wr(10'h01d, half[i]);
      sync_to(1'b0, 5);
      peek(8'h00, 8'h20);
      sync_to(1'b1, 4);
    end
    for (int s = 0; s < 2; s++) begin
      wr(10'h01c, 8'(s << 6));
      wr(10'h01d, 8'h07);
      sync_to(1'b0, 4);
      peek(8'h20, 8'h30);
      sync_to(1'b1, 6);
      peek(8'h20, 8'h30);
      pulse(!s[0], 8'h05, 1'b1, 8'h20, 8'h30);
      pulse(s[0], 8'h05, 1'b1, 8'h30, 8'h30);
      peek(8'h00, 8'h20);
    end
    $display("manual holdover done");
    wr(10'h01c, 8'h00);
    wr(10'h018, 8'h00);
    wr(10'h01a, 8'h04);
    pulse(1'b0, 8'd61, 1'b0, 8'h00, 8'h00);
    pulse(1'b0, 8'd39, 1'b0, 8'h00, 8'h00);
    locks(3);
    rd(10'h01f, 8'h00, 8'h01);
    locks(1);
    rd(10'h01f, 8'h01, 8'h01);
    repeat (12) @(posedge clk_i);
    peek(8'h08, 8'h2c);
    wr(10'h01d, 8'h0d);
    pulse(1'b0, 8'd50, 1'b0, 8'h00, 8'h00);
    rd(10'h01f, 8'ha1, 8'hb1);
    sync_to(1'b0, 5);
    peek(8'h00, 8'h20);
    sync_to(1'b1, 4);
    pulse(1'b0, 8'd61, 1'b0, 8'h00, 8'h00);
    repeat (8) @(posedge clk_i);
    peek(8'h24, 8'h2c);
    repeat (20) @(posedge clk_i);
    peek(8'h20, 8'h20);
    pulse(1'b0, 8'h05, 1'b1, 8'h30, 8'h30);
    repeat (10) @(posedge clk_i);
    rd(10'h01f, 8'h00, 8'h90);
    locks(5);
    repeat (12) @(posedge clk_i);
    rd(10'h01f, 8'ha1, 8'hb1);
    $display("automatic holdover done");
    wr(10'h01d, 8'h05);
    pulse(1'b0, 8'd61, 1'b0, 8'h00, 8'h00);
    repeat (10) @(posedge clk_i);
    peek(8'h04, 8'h24);
    wr(10'h01d, 8'h08);
    mux(1'b0, 1'b0);
    locks(5);
    repeat (12) @(posedge clk_i);
    mux(1'b1, 1'b1);
    $display("monitor pins done");
    wr(10'h018, 8'h08);
    rd(10'h01f, 8'h00, 8'h01);
    // Low window, sixteen cycles: a difference of 12 is in the wide window only
    wr(10'h018, 8'h30);
    repeat (15) pulse(1'b0, 8'd11, 1'b0, 8'h00, 8'h00);
    pulse(1'b0, 8'd12, 1'b0, 8'h00, 8'h00);
    rd(10'h01f, 8'h00, 8'h01);
    repeat (15) pulse(1'b0, 8'd11, 1'b0, 8'h00, 8'h00);
    rd(10'h01f, 8'h00, 8'h01);
    pulse(1'b0, 8'd11, 1'b0, 8'h00, 8'h00);
    rd(10'h01f, 8'h01, 8'h01);
    pulse(1'b0, 8'd18, 1'b0, 8'h00, 8'h00);
    rd(10'h01f, 8'h01, 8'h01);
    pulse(1'b0, 8'd19, 1'b0, 8'h00, 8'h00);
    rd(10'h01f, 8'h00, 8'h01);
    $display("lock window done");
    wr(10'h01b, 8'h04);
    wr(10'h017, 8'h10);
    wr(10'h01d, 8'h07);
    sync_to(1'b0, 5);
    peek(8'h23, 8'h23);
    sync_to(1'b1, 4);
    pulse(1'b0, 8'd11, 1'b1, 8'h30, 8'h30);
    repeat (2) @(posedge clk_i);
    peek(8'h00, 8'h23);
    $display("holdover monitor done");
    wrap_up();
  end
endmodule
